// ### rtl/msq_pkg.sv
package msq_pkg;
    // Opcodes seen on the link
    localparam logic [7:0] OPC_PROG = 8'h80;
    localparam logic [7:0] OPC_PROG_NEXT = 8'h81;
    localparam logic [7:0] OPC_CBPROG = 8'h85;
    localparam logic [7:0] OPC_CONF_MID = 8'h11;
    localparam logic [7:0] OPC_CONF_PROG = 8'h10;
    localparam logic [7:0] OPC_CONF_CACHE = 8'h15;
    localparam logic [7:0] OPC_ERASE = 8'h60;
    localparam logic [7:0] OPC_ERASE_MID = 8'hd1;
    localparam logic [7:0] OPC_ERASE_END = 8'hd0;
    localparam logic [7:0] OPC_READ = 8'h00;
    localparam logic [7:0] OPC_READ_END = 8'h30;
    localparam logic [7:0] OPC_READ_CACHE = 8'h31;
    localparam logic [7:0] OPC_READ_MID = 8'h32;
    localparam logic [7:0] OPC_CBREAD_END = 8'h35;
    localparam logic [7:0] OPC_STATUS = 8'h70;
    // Address cycles per sub-operation
    localparam int COL_BYTES = 2;
    localparam int ROW_BYTES = 3;
    // Status byte bit positions
    localparam int ST_FAIL = 0;
    localparam int ST_PREVIOUS_OP_FAIL_FLAG = 1;
    localparam int ST_VENDOR_SPECIFIC_BIT = 4;
    localparam int ST_ARRAY_READY_FLAG = 5;
    localparam int ST_RDY = 6;
    localparam int ST_WPN = 7;
    localparam logic VENDOR_SPECIFIC_VALUE = 1'b0;
    // Host register offsets and fields
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ROW = 8'h04;
    localparam logic [7:0] REG_COL = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP = 1;
    localparam int CTRL_NPL = 4;
    localparam int CTRL_ALT81 = 8;
    localparam int CTRL_CACHE = 9;
    localparam int CTRL_DLEN = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_BYTE = 8;
    localparam int ARRAY_CYC = 16;
    typedef enum logic [2:0] {
        MSQ_OP_NONE, MSQ_OP_PROG, MSQ_OP_CBREAD, MSQ_OP_CBPROG,
        MSQ_OP_ERASE, MSQ_OP_READ
    } msq_op_t;
endpackage

// ### rtl/msq_link_if.sv
`timescale 1ns/1ps
interface msq_link_if;
    logic cle;
    logic ale;
    logic wr;
    logic rd;
    logic [7:0] dq_h2d;
    logic [7:0] dq_d2h;
    logic d2h_valid;
    logic rdy;
    modport dev (input cle, ale, wr, rd, dq_h2d,
                 output dq_d2h, d2h_valid, rdy);
    modport host (output cle, ale, wr, rd, dq_h2d,
                  input dq_d2h, d2h_valid, rdy);
endinterface

// ### rtl/msq_lun.sv
`timescale 1ns/1ps
// Behaviour
// - One op type per sequence, distinct blocks
// - Plane is lowest block address bits
// - Host keeps LUN and page equal
// - Host keeps non-plane block bits if required
// - Concurrent mode defers all array accesses
// - Overlapped mode starts each plane immediately
// - Program confirms 11h, final 10h/15h
// - Erase planes distinct until D0h
// - Read planes distinct until 30h/31h
// - Fail bits 0 and 1 per plane
// - Status bits 7..2 shared by LUN
// - Program opens 80h, later 80h/81h
// - 15h final only with cache support
// - Copyback reads cover copyback program planes
// - Multi-plane source reads share page
// - Copyback program opens 85h, later 85h/81h
// - Copyback destinations share page, distinct planes
// - Managed ECC may waive plane matching
// - Two column then three row bytes, LSB first
// - Erase separators 60h/D1h, close 60h/D0h
// - Host selects plane before read-out
module msq_lun import msq_pkg::*; #(
    parameter int PLANE_BITS = 1,
    parameter int PAGE_BITS = 6,
    parameter int ARRAY_CYCLES = ARRAY_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Link to the host controller
    msq_link_if.dev lnk,
    // Mode and capability straps
    input wire logic overlap_mode_in,
    input wire logic alt81_en_in,
    input wire logic same_blk_req_in,
    input wire logic ecc_relax_in,
    input wire logic wp_n_in,
    // Array side
    input wire logic [(1<<PLANE_BITS)-1:0] array_fail_in,
    output logic [(1<<PLANE_BITS)-1:0] array_start_out,
    output logic [8*ROW_BYTES-1:0] array_row_out,
    output msq_op_t array_op_out,
    output logic [7:0] wr_data_out,
    output logic wr_data_valid_out,
    output logic [(1<<PLANE_BITS)-1:0] plane_busy_out,
    output logic seq_err_out
);
    localparam int NPL = 1 << PLANE_BITS;
    localparam int ROWW = 8 * ROW_BYTES;
    localparam int CW = $clog2(ARRAY_CYCLES + 1);
    localparam logic [CW-1:0] ARR_LD = CW'(ARRAY_CYCLES);
    localparam logic [2:0] ADDR_LAST = 3'(COL_BYTES + ROW_BYTES - 1);
    localparam logic [2:0] ROW_FIRST = 3'(COL_BYTES);

    typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA} msq_st_t;
    typedef struct packed {
        msq_st_t st;
        msq_op_t op;
        msq_op_t aop;
        logic first;
        logic [2:0] acnt;
        logic [ROWW-1:0] row;
        logic [ROWW-1:0] row0;
        logic [PLANE_BITS-1:0] lastp;
        logic [NPL-1:0] used;
        logic [NPL-1:0] pend;
        logic [NPL-1:0] cbsrc;
        logic [NPL-1:0] busy;
        logic [NPL-1:0] pe;
        logic [NPL-1:0] fcur;
        logic [NPL-1:0] fprev;
        logic [NPL-1:0][CW-1:0] cnt;
        logic [NPL-1:0] start;
        logic stat_mode;
        logic seq_err;
        logic rdy;
        logic dv;
        logic [7:0] dq;
        logic wdv;
        logic [7:0] wd;
    } msq_dev_t;

    msq_dev_t r_ff;
    msq_dev_t nxt_r;

    function automatic logic [PLANE_BITS-1:0] plane_of(
        input logic [ROWW-1:0] row);
        return row[PAGE_BITS +: PLANE_BITS];
    endfunction

    always_comb begin
        logic [7:0] stat;
        logic [7:0] c;
        msq_op_t kind;
        logic bad;
        logic mid;
        logic fin;
        logic skipc;
        logic [NPL-1:0] lm;
        logic [PLANE_BITS-1:0] p;
        logic [2:0] ri;
        stat = '0;
        c = lnk.dq_h2d;
        kind = MSQ_OP_NONE;
        bad = 1'b0;
        mid = 1'b0;
        fin = 1'b0;
        skipc = 1'b0;
        lm = '0;
        p = '0;
        ri = '0;
        nxt_r = r_ff;
        nxt_r.start = '0;
        nxt_r.dv = 1'b0;
        nxt_r.wdv = 1'b0;
        for (int i = 0; i < NPL; i++) begin
            if (r_ff.busy[i]) begin
                if (r_ff.cnt[i] == CW'(1)) begin
                    nxt_r.busy[i] = 1'b0;
                    if (r_ff.pe[i]) begin
                        nxt_r.fprev[i] = r_ff.fcur[i];
                        nxt_r.fcur[i] = array_fail_in[i];
                    end
                end else begin
                    nxt_r.cnt[i] = r_ff.cnt[i] - CW'(1);
                end
            end
        end
        // Shared bits come from LUN-wide state, fail bits from the
        // plane addressed last
        stat[ST_WPN] = wp_n_in;
        stat[ST_RDY] = r_ff.rdy;
        stat[ST_ARRAY_READY_FLAG] = ~|r_ff.busy;
        stat[ST_VENDOR_SPECIFIC_BIT] = VENDOR_SPECIFIC_VALUE;
        stat[ST_PREVIOUS_OP_FAIL_FLAG] = r_ff.fprev[r_ff.lastp];
        stat[ST_FAIL] = r_ff.fcur[r_ff.lastp];
        if (lnk.rd) begin
            nxt_r.dv = 1'b1;
            nxt_r.dq = r_ff.stat_mode ? stat : 8'h00;
        end
        if (lnk.wr && lnk.cle) begin
            nxt_r.stat_mode = (c == OPC_STATUS);
            if (c == OPC_PROG) begin
                kind = MSQ_OP_PROG;
            end else if (c == OPC_CBPROG) begin
                kind = MSQ_OP_CBPROG;
            end else if (c == OPC_ERASE) begin
                kind = MSQ_OP_ERASE;
                skipc = 1'b1;
            end else if (c == OPC_READ) begin
                kind = MSQ_OP_READ;
            end else if (c == OPC_PROG_NEXT) begin
                kind = r_ff.op;
                bad = r_ff.first || !alt81_en_in ||
                      (r_ff.op != MSQ_OP_PROG && r_ff.op != MSQ_OP_CBPROG);
            end else if (c == OPC_CONF_MID) begin
                mid = 1'b1;
                bad = r_ff.op != MSQ_OP_PROG && r_ff.op != MSQ_OP_CBPROG;
            end else if (c == OPC_ERASE_MID) begin
                mid = 1'b1;
                bad = r_ff.op != MSQ_OP_ERASE;
            end else if (c == OPC_READ_MID) begin
                mid = 1'b1;
                bad = r_ff.op != MSQ_OP_READ;
            end else if (c == OPC_CONF_PROG || c == OPC_CONF_CACHE) begin
                fin = 1'b1;
                bad = r_ff.op != MSQ_OP_PROG && r_ff.op != MSQ_OP_CBPROG;
            end else if (c == OPC_ERASE_END) begin
                fin = 1'b1;
                bad = r_ff.op != MSQ_OP_ERASE;
            end else if (c == OPC_READ_END || c == OPC_READ_CACHE ||
                         c == OPC_CBREAD_END) begin
                fin = 1'b1;
                bad = r_ff.op != MSQ_OP_READ;
            end
            if (kind != MSQ_OP_NONE) begin
                bad = bad || r_ff.st != S_IDLE ||
                      (!r_ff.first && r_ff.op != kind);
                nxt_r.op = kind;
                nxt_r.st = S_ADDR;
                nxt_r.acnt = skipc ? ROW_FIRST : 3'h0;
                if (r_ff.first && !bad) begin
                    nxt_r.seq_err = 1'b0;
                end
            end
            if (mid || fin) begin
                bad = bad || r_ff.st != S_DATA;
                nxt_r.st = S_IDLE;
                nxt_r.aop = (c == OPC_CBREAD_END) ? MSQ_OP_CBREAD : r_ff.op;
            end
            if (mid && !bad) begin
                nxt_r.first = 1'b0;
                if (overlap_mode_in) begin
                    lm[r_ff.lastp] = 1'b1;
                end else begin
                    nxt_r.pend[r_ff.lastp] = 1'b1;
                end
            end
            if (fin && !bad) begin
                lm = r_ff.pend;
                lm[r_ff.lastp] = 1'b1;
                if (c == OPC_CBREAD_END) begin
                    nxt_r.cbsrc = r_ff.used;
                end else if (r_ff.op == MSQ_OP_CBPROG) begin
                    nxt_r.cbsrc = '0;
                end
                nxt_r.used = '0;
                nxt_r.pend = '0;
                nxt_r.first = 1'b1;
                nxt_r.op = MSQ_OP_NONE;
            end
        end else if (lnk.wr && lnk.ale && r_ff.st == S_ADDR) begin
            if (r_ff.acnt >= ROW_FIRST) begin
                ri = r_ff.acnt - ROW_FIRST;
                nxt_r.row[8*ri +: 8] = c;
            end
            nxt_r.acnt = r_ff.acnt + 3'h1;
            if (r_ff.acnt == ADDR_LAST) begin
                p = plane_of(nxt_r.row);
                bad = r_ff.used[p];
                if (!r_ff.first && r_ff.op != MSQ_OP_ERASE &&
                    nxt_r.row[PAGE_BITS-1:0] != r_ff.row0[PAGE_BITS-1:0])
                begin
                    bad = 1'b1;
                end
                if (!r_ff.first && same_blk_req_in &&
                    nxt_r.row[ROWW-1:PAGE_BITS+PLANE_BITS] !=
                    r_ff.row0[ROWW-1:PAGE_BITS+PLANE_BITS]) begin
                    bad = 1'b1;
                end
                if (r_ff.op == MSQ_OP_CBPROG && !ecc_relax_in &&
                    !r_ff.cbsrc[p]) begin
                    bad = 1'b1;
                end
                if (r_ff.first) begin
                    nxt_r.row0 = nxt_r.row;
                end
                nxt_r.used[p] = 1'b1;
                nxt_r.lastp = p;
                nxt_r.st = S_DATA;
            end
        end else if (lnk.wr && !lnk.ale && r_ff.st == S_DATA &&
                     (r_ff.op == MSQ_OP_PROG ||
                      r_ff.op == MSQ_OP_CBPROG)) begin
            nxt_r.wdv = 1'b1;
            nxt_r.wd = c;
        end
        for (int i = 0; i < NPL; i++) begin
            if (lm[i]) begin
                nxt_r.busy[i] = 1'b1;
                nxt_r.cnt[i] = ARR_LD;
                nxt_r.pe[i] = r_ff.op != MSQ_OP_READ;
            end
        end
        nxt_r.start = lm;
        // A bad cycle abandons the sequence; the error flag is set
        // after any clear so a same-cycle violation is never lost
        if (bad) begin
            nxt_r.seq_err = 1'b1;
            nxt_r.st = S_IDLE;
            nxt_r.op = MSQ_OP_NONE;
            nxt_r.used = '0;
            nxt_r.pend = '0;
            nxt_r.first = 1'b1;
            nxt_r.start = '0;
            nxt_r.busy = r_ff.busy & nxt_r.busy;
        end
        nxt_r.rdy = ~|nxt_r.busy;
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            r_ff <= '0;
            r_ff.first <= 1'b1;
            r_ff.rdy <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign lnk.rdy = r_ff.rdy;
    assign lnk.dq_d2h = r_ff.dq;
    assign lnk.d2h_valid = r_ff.dv;
    assign array_start_out = r_ff.start;
    assign array_row_out = r_ff.row;
    assign array_op_out = r_ff.aop;
    assign wr_data_out = r_ff.wd;
    assign wr_data_valid_out = r_ff.wdv;
    assign plane_busy_out = r_ff.busy;
    assign seq_err_out = r_ff.seq_err;
endmodule

// ### rtl/msq_host.sv
`timescale 1ns/1ps
module msq_host import msq_pkg::*; #(
    parameter int PLANE_BITS = 1,
    parameter int PAGE_BITS = 6
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // APB register port
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Link to the flash unit
    msq_link_if.host lnk
);
    localparam int ROWW = 8 * ROW_BYTES;
    localparam logic [2:0] ADDR_LAST = 3'(COL_BYTES + ROW_BYTES - 1);
    typedef enum logic [3:0] {
        H_IDLE, H_WRDY, H_CMD, H_ADDR, H_DATA, H_CONF, H_SCMD, H_SWAIT,
        H_SRD, H_SGET
    } msq_hst_t;
    typedef struct packed {
        msq_hst_t st;
        msq_op_t op;
        logic [3:0] npl;
        logic alt;
        logic cache;
        logic [7:0] dlen;
        logic [ROWW-1:0] row;
        logic [15:0] col;
        logic [3:0] sub;
        logic [2:0] k;
        logic [7:0] dcnt;
        logic busy;
        logic done;
        logic [7:0] sbyte;
        logic cle;
        logic ale;
        logic wr;
        logic rd;
        logic [7:0] dq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } msq_host_t;

    msq_host_t r_ff;
    msq_host_t nxt_r;

    function automatic logic [7:0] conf_opc(input msq_op_t op,
                                            input logic last,
                                            input logic cache);
        logic [7:0] o;
        o = OPC_CONF_MID;
        if (op == MSQ_OP_ERASE) begin
            o = last ? OPC_ERASE_END : OPC_ERASE_MID;
        end else if (op == MSQ_OP_READ) begin
            o = !last ? OPC_READ_MID :
                (cache ? OPC_READ_CACHE : OPC_READ_END);
        end else if (op == MSQ_OP_CBREAD) begin
            o = last ? OPC_CBREAD_END : OPC_READ_MID;
        end else if (last) begin
            // Cache finish only where software says it is supported
            o = (cache && op == MSQ_OP_PROG) ? OPC_CONF_CACHE :
                OPC_CONF_PROG;
        end
        return o;
    endfunction

    always_comb begin
        logic [7:0] o;
        logic [ROWW-1:0] rowp;
        logic last;
        logic [2:0] ri;
        o = 8'h00;
        rowp = r_ff.row;
        rowp[PAGE_BITS +: PLANE_BITS] = r_ff.sub[PLANE_BITS-1:0];
        last = r_ff.sub == r_ff.npl - 4'h1;
        ri = r_ff.k - 3'(COL_BYTES);
        nxt_r = r_ff;
        nxt_r.cle = 1'b0;
        nxt_r.ale = 1'b0;
        nxt_r.wr = 1'b0;
        nxt_r.rd = 1'b0;
        nxt_r.pready = 1'b0;
        nxt_r.pslverr = 1'b0;
        // Answer in the first access cycle: data is staged at setup
        if (psel_in && !penable_in) begin
            nxt_r.pready = 1'b1;
            nxt_r.prdata = '0;
            if (paddr_in == REG_CTRL) begin
                nxt_r.prdata[CTRL_OP +: 3] = r_ff.op;
                nxt_r.prdata[CTRL_NPL +: 4] = r_ff.npl;
                nxt_r.prdata[CTRL_ALT81] = r_ff.alt;
                nxt_r.prdata[CTRL_CACHE] = r_ff.cache;
                nxt_r.prdata[CTRL_DLEN +: 8] = r_ff.dlen;
            end else if (paddr_in == REG_ROW) begin
                nxt_r.prdata[ROWW-1:0] = r_ff.row;
            end else if (paddr_in == REG_COL) begin
                nxt_r.prdata[15:0] = r_ff.col;
            end else if (paddr_in == REG_STAT) begin
                nxt_r.prdata[STAT_BUSY] = r_ff.busy;
                nxt_r.prdata[STAT_DONE] = r_ff.done;
                nxt_r.prdata[STAT_BYTE +: 8] = r_ff.sbyte;
            end else begin
                nxt_r.pslverr = 1'b1;
            end
        end
        if (psel_in && penable_in && r_ff.pready && pwrite_in &&
            !r_ff.busy) begin
            if (paddr_in == REG_CTRL) begin
                nxt_r.op = msq_op_t'(pwdata_in[CTRL_OP +: 3]);
                nxt_r.npl = pwdata_in[CTRL_NPL +: 4];
                nxt_r.alt = pwdata_in[CTRL_ALT81];
                nxt_r.cache = pwdata_in[CTRL_CACHE];
                nxt_r.dlen = pwdata_in[CTRL_DLEN +: 8];
                if (pwdata_in[CTRL_GO] && pwdata_in[CTRL_NPL +: 4] != 4'h0)
                begin
                    nxt_r.busy = 1'b1;
                    nxt_r.done = 1'b0;
                    nxt_r.sub = 4'h0;
                    nxt_r.st = H_WRDY;
                end
            end else if (paddr_in == REG_ROW) begin
                nxt_r.row = pwdata_in[ROWW-1:0];
            end else if (paddr_in == REG_COL) begin
                nxt_r.col = pwdata_in[15:0];
            end
        end
        case (r_ff.st)
            H_IDLE: begin
                // Start comes from the register write above
            end
            H_WRDY: begin
                if (lnk.rdy) begin
                    nxt_r.st = H_CMD;
                end
            end
            H_CMD: begin
                if (r_ff.op == MSQ_OP_PROG) begin
                    o = (r_ff.sub != 4'h0 && r_ff.alt) ? OPC_PROG_NEXT :
                        OPC_PROG;
                end else if (r_ff.op == MSQ_OP_CBPROG) begin
                    o = (r_ff.sub != 4'h0 && r_ff.alt) ? OPC_PROG_NEXT :
                        OPC_CBPROG;
                end else if (r_ff.op == MSQ_OP_ERASE) begin
                    o = OPC_ERASE;
                end else begin
                    o = OPC_READ;
                end
                nxt_r.cle = 1'b1;
                nxt_r.wr = 1'b1;
                nxt_r.dq = o;
                nxt_r.k = (r_ff.op == MSQ_OP_ERASE) ? 3'(COL_BYTES) : 3'h0;
                nxt_r.st = H_ADDR;
            end
            H_ADDR: begin
                nxt_r.ale = 1'b1;
                nxt_r.wr = 1'b1;
                nxt_r.dq = (r_ff.k < 3'(COL_BYTES)) ?
                    r_ff.col[8*r_ff.k[0] +: 8] : rowp[8*ri +: 8];
                nxt_r.k = r_ff.k + 3'h1;
                nxt_r.dcnt = 8'h00;
                if (r_ff.k == ADDR_LAST) begin
                    nxt_r.st = (r_ff.op == MSQ_OP_PROG && r_ff.dlen != 8'h00)
                        ? H_DATA : H_CONF;
                end
            end
            H_DATA: begin
                nxt_r.wr = 1'b1;
                nxt_r.dq = r_ff.dcnt;
                nxt_r.dcnt = r_ff.dcnt + 8'h01;
                if (r_ff.dcnt == r_ff.dlen - 8'h01) begin
                    nxt_r.st = H_CONF;
                end
            end
            H_CONF: begin
                nxt_r.cle = 1'b1;
                nxt_r.wr = 1'b1;
                nxt_r.dq = conf_opc(r_ff.op, last, r_ff.cache);
                nxt_r.sub = r_ff.sub + 4'h1;
                nxt_r.st = last ? H_SCMD : H_CMD;
            end
            H_SCMD: begin
                nxt_r.cle = 1'b1;
                nxt_r.wr = 1'b1;
                nxt_r.dq = OPC_STATUS;
                nxt_r.st = H_SWAIT;
            end
            H_SWAIT: begin
                if (lnk.rdy) begin
                    nxt_r.st = H_SRD;
                end
            end
            H_SRD: begin
                // Only status is read back, so no plane select is needed
                nxt_r.rd = 1'b1;
                nxt_r.st = H_SGET;
            end
            H_SGET: begin
                if (lnk.d2h_valid) begin
                    nxt_r.sbyte = lnk.dq_d2h;
                    nxt_r.done = 1'b1;
                    nxt_r.busy = 1'b0;
                    nxt_r.st = H_IDLE;
                end
            end
            default: begin
                nxt_r.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign lnk.cle = r_ff.cle;
    assign lnk.ale = r_ff.ale;
    assign lnk.wr = r_ff.wr;
    assign lnk.rd = r_ff.rd;
    assign lnk.dq_h2d = r_ff.dq;
    assign prdata_out = r_ff.prdata;
    assign pready_out = r_ff.pready;
    assign pslverr_out = r_ff.pslverr;
endmodule

// ### sim/msq_link_monitor.sv
`timescale 1ns/1ps
module msq_link_monitor import msq_pkg::*; (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Link, both directions
    input wire logic cle,
    input wire logic ale,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] dq_h2d,
    input wire logic [7:0] dq_d2h,
    input wire logic d2h_valid,
    input wire logic rdy
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Remembers whether the last command byte asked for status
    logic st_ff;
    logic nxt_st;
    always_comb begin
        nxt_st = st_ff;
        if (cle && wr) nxt_st = (dq_h2d == OPC_STATUS);
    end
    always_ff @(posedge sys_clk_in) st_ff <= sys_rst_in ? 1'b0 : nxt_st;
    AST_RD_ANSWER: assert property (rd |=> d2h_valid)
        else $error("no byte one cycle after read strobe");
    AST_NO_STRAY: assert property (!rd |=> !d2h_valid)
        else $error("byte returned without read strobe");
    AST_CMD_QUAL: assert property (cle |-> wr && !ale)
        else $error("command latch without lone strobe");
    AST_ADR_QUAL: assert property (ale |-> wr)
        else $error("address latch without strobe");
    AST_PROG_ADDR: assert property (cle && wr && dq_h2d == OPC_PROG
        |=> (ale && wr) [*5])
        else $error("program opening not followed by five addresses");
    AST_ERASE_ADDR: assert property (cle && wr && dq_h2d == OPC_ERASE
        |=> ale [*3] ##1 cle)
        else $error("erase row not three bytes then command");
    AST_CONF_BUSY: assert property (cle && wr && (dq_h2d == OPC_CONF_PROG
        || dq_h2d == OPC_ERASE_END) |=> !rdy)
        else $error("unit ready after final confirm");
    AST_STAT_BYTE: assert property (d2h_valid && st_ff |->
        dq_d2h[ST_RDY] == $past(rdy) &&
        dq_d2h[ST_ARRAY_READY_FLAG] == dq_d2h[ST_RDY]
        && dq_d2h[3:2] == 2'b00)
        else $error("shared status bits wrong");
endmodule

// ### sim/tb_multi_plane_op_sequencer.sv
`timescale 1ns/1ps
module tb_multi_plane_op_sequencer import msq_pkg::*; ;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic ovl = 0, a81 = 0, sbr = 0, ecc = 0, wp = 1;
    logic [7:0] pa = 0, wdo;
    logic [31:0] pwd = 0, prd, seed = 32'h4f46675a;
    logic prdy, perr, wdv, serr;
    logic [1:0] afail = 0, ast, pbusy;
    logic [23:0] arow;
    msq_op_t aop;
    int miscompares = 0, tests_run = 0, scyc, wrd, alec;
    logic pf = 0;
    always #12.5 clk = ~clk;
    msq_link_if lnk();
    msq_host msq_host_inst(.sys_clk_in(clk), .sys_rst_in(rst),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
        .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .lnk(lnk));
    msq_lun msq_lun_inst(.sys_clk_in(clk), .sys_rst_in(rst), .lnk(lnk),
        .overlap_mode_in(ovl), .alt81_en_in(a81), .same_blk_req_in(sbr),
        .ecc_relax_in(ecc), .wp_n_in(wp), .array_fail_in(afail),
        .array_start_out(ast), .array_row_out(arow), .array_op_out(aop),
        .wr_data_out(wdo), .wr_data_valid_out(wdv),
        .plane_busy_out(pbusy), .seq_err_out(serr));
    msq_link_monitor msq_link_monitor_inst(.sys_clk_in(clk),
        .sys_rst_in(rst), .cle(lnk.cle), .ale(lnk.ale), .wr(lnk.wr),
        .rd(lnk.rd), .dq_h2d(lnk.dq_h2d), .dq_d2h(lnk.dq_d2h),
        .d2h_valid(lnk.d2h_valid), .rdy(lnk.rdy));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] exp_stat(input logic fc, input logic f);
        return {24'h0, wp, 2'b11, VENDOR_SPECIFIC_VALUE, 2'b00, fc, f};
    endfunction
    // Launch cycles, program bytes and address bytes of the current op
    always @(posedge clk) begin
        if (ast != 2'b00) scyc++;
        wrd += int'(wdv);
        alec += int'(lnk.ale & lnk.wr);
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic run(input logic [2:0] op, input logic err);
        logic [31:0] q, row, dl, m;
        logic e, ca, pe;
        row = rnd() & 32'h00ffffff;
        dl = (op == 3'd1) ? (rnd() & 32'h3) + 32'd1 : 32'd0;
        q = rnd();
        afail <= q[1:0];
        ca = (op == 3'd1) & q[5];
        scyc = 0;
        wrd = 0;
        alec = 0;
        apb(1'b1, REG_ROW, row, q, e);
        apb(1'b1, REG_COL, rnd() & 32'hffff, q, e);
        apb(1'b1, REG_CTRL, (dl << CTRL_DLEN) | (32'(ca) << CTRL_CACHE)
            | (32'(a81) << CTRL_ALT81) | ((32'd2 + 32'(err)) << CTRL_NPL)
            | (32'(op) << CTRL_OP) | 32'd1, q, e);
        do apb(1'b0, REG_STAT, 32'd0, q, e);
        while (!(q[STAT_DONE] === 1'b1 && q[STAT_BUSY] === 1'b0));
        if (err) begin
            // Third sub-op reuses plane 0: dropped before deferred launch
            chk(scyc, ovl ? 2 : 0);
            chk(serr, 32'd1);
        end else begin
            chk(scyc, ovl ? 2 : 1);
            chk(alec, (op == 3'd4) ? 6 : 10);
            chk(wrd, dl * 2);
            if (op == 3'd1) chk(wdo, dl - 32'd1);
            chk(arow, row | 32'h40);
            chk({aop, serr}, {op, 1'b0});
            chk(pbusy, 32'd0);
            // Fail bits only mean something after program or erase
            pe = op != 3'd2 && op != 3'd5;
            m = pe ? 32'hff : 32'hfc;
            chk(q[15:8] & m, exp_stat(pf, afail[1]) & m);
            if (pe) pf = afail[1];
        end
        $display("test op %0d done", op);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        logic [31:0] q;
        logic e;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h10, 32'd0, q, e);
        chk(q, 32'd0);
        chk(32'(e), 32'd1);
        $display("test unmapped done");
        // Both modes forced first, then random straps
        for (int k = 0; k < 4; k++) begin
            q = rnd();
            ovl <= (k < 2) ? k[0] : q[0];
            a81 <= q[1];
            sbr <= q[2];
            ecc <= q[3];
            wp <= q[4];
            run(3'd1, 1'b0);
            run(3'd4, 1'b0);
            run(3'd5, 1'b0);
            run(3'd5, 1'b1);
            run(3'd2, 1'b0);
            run(3'd3, 1'b0);
        end
        end_sim();
    end
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule
